// *** usss_pkg.sv ***
// Constants, register map and types for the synchronous slave serial port.
// Assumes an APB master with 32-bit data; registers sit in the low 8 bits of a word.
package usss_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h18;
   localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h19;
   localparam logic [7:0] IDX_TRANSMIT_BUFFER = 8'h1A;
   localparam logic [7:0] IDX_RECEIVE_BUFFER = 8'h1B;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
   localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int BIT_RECEIVE_COMPLETE = 5;
   localparam int BIT_TRANSMIT_BUFFER_EMPTY = 4;
   localparam int BIT_CLOCK_SOURCE_SELECT = 7;
   localparam int BIT_NINE_BIT_TRANSMIT = 6;
   localparam int BIT_TRANSMIT_ENABLE = 5;
   localparam int BIT_SYNC_MODE = 4;
   localparam int BIT_SHIFT_REG_EMPTY = 1;
   localparam int BIT_TRANSMIT_NINTH = 0;
   localparam int BIT_SERIAL_PORT_ENABLE = 7;
   localparam int BIT_NINE_BIT_RECEIVE = 6;
   localparam int BIT_SINGLE_RECEIVE = 5;
   localparam int BIT_CONTINUOUS_RECEIVE = 4;
   localparam int BIT_OVERRUN_ERROR = 1;
   localparam int BIT_RECEIVE_NINTH = 0;

   // ----------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
   localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
   localparam logic [2:0] RST_CLK_SYNC = 3'h7;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [3:0] WORD_BITS_SHORT = 4'h8;
   localparam logic [3:0] WORD_BITS_LONG = 4'h9;
   localparam logic [7:0] MASK_PERIPH_FLAGS = 8'h30;
   localparam logic [7:0] MASK_TXSC_WRITE = 8'hF1;
   localparam logic [7:0] MASK_RXSC_WRITE = 8'hF0;

   typedef enum logic [1:0] {
      USSS_TX_IDLE = 2'b01,
      USSS_TX_SHIFT = 2'b10
   } usss_tx_state_t;

endpackage // usss_pkg

// *** usss_top.sv ***
// Synchronous slave serial port: APB registers, transmit and receive shifters.
// Assumes the external master drives shift_clock_pin; pins are asynchronous to clk_sys.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns

// What this block does
// - Shift clock comes from the external pin, never generated; works while core sleeps.
// - Slave mode is active while clock source select, bit 7, is clear.
// - Slave transmit and receive follow master-mode behaviour except during sleep.
// - Two writes: first goes straight to shifter, second waits, flag stays clear.
// - After the first word leaves, the second is loaded and empty flag set.
// - Enabled transmit interrupt wakes the device; with global and peripheral enables, vector 0004h.
// - Transmit enable allows sending; a write to the transmit buffer starts it.
// - Single receive enable is ignored in slave mode.
// - With continuous receive set, words are accepted during sleep.
// - Complete word moves to receive buffer; enabled interrupt wakes the device.
// - Receive complete flag sets on finish; interrupt only when enabled.
// - Nine-bit receive select gives nine-bit words; ninth bit in receive status.
// - Receive status reports any reception error.
// - Received byte is read as 8 bits from the receive buffer.
// - Clearing continuous receive enable clears the error indications.
module usss_top (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic shift_clock_pin,
   input wire logic data_pin_in,
   output logic data_pin_out,
   output logic data_pin_oe,
   output logic irq_req,
   output logic wake_req,
   output logic [12:0] irq_vector
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] interrupt_control;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] txsc;
      logic [7:0] rxsc;
      logic [8:0] tx_buf;
      logic tx_buf_full;
      logic [8:0] transmit_shift_register;
      logic [3:0] tx_left;
      usss_pkg::usss_tx_state_t tx_state;
      logic [8:0] receive_shift_register;
      logic [3:0] rx_cnt;
      logic [7:0] rx_buf;
      logic rx_buf_full;
      logic [2:0] clk_sync;
      logic [1:0] dat_sync;
      logic [31:0] rdata;
      logic slverr;
   } usss_state_t;

   usss_state_t st_r;
   usss_state_t st_nxt;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] usss_word_bits(input logic nine);
      return nine ? usss_pkg::WORD_BITS_LONG : usss_pkg::WORD_BITS_SHORT;
   endfunction

   function automatic logic usss_hit(input logic [31:0] addr, input logic [7:0] idx);
      return addr == {22'h0, idx, 2'b00};
   endfunction

   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wb;
   logic port_on;
   logic clk_rise;
   logic clk_fall;
   logic din;
   logic tx_mode;
   logic rx_mode;
   logic tx_done_evt;
   logic rx_done_evt;
   logic [7:0] pending;
   logic hit_interrupt_control;
   logic hit_flags;
   logic hit_enables;
   logic hit_txsc;
   logic hit_rxsc;
   logic hit_txbuf;
   logic hit_rxbuf;
   logic hit_any;

   assign acc = psel && penable;
   assign wr = acc && pwrite && pstrb[0];
   assign rd = acc && !pwrite;
   assign wb = pwdata[7:0];

   // ----------------------------------------------------------------
   // Address decode, shared by writes, reads and the error response
   // ----------------------------------------------------------------
   assign hit_interrupt_control = usss_hit(paddr, usss_pkg::IDX_INTERRUPT_CONTROL);
   assign hit_flags = usss_hit(paddr, usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
   assign hit_enables = usss_hit(paddr, usss_pkg::IDX_PERIPHERAL_IRQ_ENABLES);
   assign hit_txsc = usss_hit(paddr, usss_pkg::IDX_TRANSMIT_STATUS_CONTROL);
   assign hit_rxsc = usss_hit(paddr, usss_pkg::IDX_RECEIVE_STATUS_CONTROL);
   assign hit_txbuf = usss_hit(paddr, usss_pkg::IDX_TRANSMIT_BUFFER);
   assign hit_rxbuf = usss_hit(paddr, usss_pkg::IDX_RECEIVE_BUFFER);
   assign hit_any = hit_interrupt_control || hit_flags || hit_enables || hit_txsc ||
                    hit_rxsc || hit_txbuf || hit_rxbuf;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Slave mode only: external clock, sync mode, port enabled
   assign port_on = st_r.rxsc[usss_pkg::BIT_SERIAL_PORT_ENABLE] &&
                    st_r.txsc[usss_pkg::BIT_SYNC_MODE] &&
                    !st_r.txsc[usss_pkg::BIT_CLOCK_SOURCE_SELECT];

   // ----------------------------------------------------------------
   // Pin edges
   // ----------------------------------------------------------------
   // Edges found on the second and third sync stages
   // Each pin level must last a few system clocks or an edge is lost
   assign clk_rise = st_r.clk_sync[1] && !st_r.clk_sync[2];
   assign clk_fall = !st_r.clk_sync[1] && st_r.clk_sync[2];
   assign din = st_r.dat_sync[1];

   // ----------------------------------------------------------------
   // Transfer direction and interrupt sources
   // ----------------------------------------------------------------
   assign tx_mode = port_on && st_r.txsc[usss_pkg::BIT_TRANSMIT_ENABLE];
   // Single receive enable deliberately not looked at
   assign rx_mode = port_on && st_r.rxsc[usss_pkg::BIT_CONTINUOUS_RECEIVE] &&
                    !tx_mode;
   assign pending = st_r.flags & st_r.enables & usss_pkg::MASK_PERIPH_FLAGS;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      tx_done_evt = 1'b0;
      rx_done_evt = 1'b0;
      st_nxt.clk_sync = {st_r.clk_sync[1:0], shift_clock_pin};
      st_nxt.dat_sync = {st_r.dat_sync[0], data_pin_in};

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr) begin
         if (hit_interrupt_control) begin
            st_nxt.interrupt_control = wb;
         end
         if (hit_flags) begin
            st_nxt.flags = st_r.flags & ~(wb & usss_pkg::MASK_PERIPH_FLAGS);
         end
         if (hit_enables) begin
            st_nxt.enables = wb;
         end
         if (hit_txsc) begin
            st_nxt.txsc = (wb & usss_pkg::MASK_TXSC_WRITE) |
                          (st_r.txsc & ~usss_pkg::MASK_TXSC_WRITE);
         end
         if (hit_rxsc) begin
            st_nxt.rxsc = (wb & usss_pkg::MASK_RXSC_WRITE) |
                          (st_r.rxsc & ~usss_pkg::MASK_RXSC_WRITE);
         end
         if (hit_txbuf && !st_r.tx_buf_full) begin
            // Ninth bit latched with the word
            st_nxt.tx_buf = {st_r.txsc[usss_pkg::BIT_TRANSMIT_NINTH], wb};
            st_nxt.tx_buf_full = 1'b1;
         end
      end

      // Reading the receive buffer frees it
      if (rd && hit_rxbuf) begin
         st_nxt.rx_buf_full = 1'b0;
      end

      // ----------------------------------------------------------------
      // Transmit shifter
      // ----------------------------------------------------------------
      if (!tx_mode) begin
         st_nxt.tx_state = usss_pkg::USSS_TX_IDLE;
         st_nxt.tx_left = 4'h0;
      end else begin
         unique case (st_r.tx_state)
            usss_pkg::USSS_TX_IDLE: begin
               if (st_r.tx_buf_full) begin
                  // First word moves straight in, flag untouched
                  st_nxt.transmit_shift_register = st_r.tx_buf;
                  st_nxt.tx_buf_full = 1'b0;
                  st_nxt.tx_left = usss_word_bits(st_r.txsc[usss_pkg::BIT_NINE_BIT_TRANSMIT]);
                  st_nxt.tx_state = usss_pkg::USSS_TX_SHIFT;
               end
            end
            usss_pkg::USSS_TX_SHIFT: begin
               if (clk_rise) begin
                  if (st_r.tx_left > 4'h1) begin
                     st_nxt.transmit_shift_register = {1'b0, st_r.transmit_shift_register[8:1]};
                     st_nxt.tx_left = st_r.tx_left - 4'h1;
                  end else begin
                     tx_done_evt = 1'b1;
                     if (st_r.tx_buf_full) begin
                        // Buffered word handed over as the previous one ends
                        st_nxt.transmit_shift_register = st_r.tx_buf;
                        st_nxt.tx_buf_full = 1'b0;
                        st_nxt.tx_left =
                           usss_word_bits(st_r.txsc[usss_pkg::BIT_NINE_BIT_TRANSMIT]);
                     end else begin
                        st_nxt.tx_left = 4'h0;
                        st_nxt.tx_state = usss_pkg::USSS_TX_IDLE;
                     end
                  end
               end
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Receive shifter
      // ----------------------------------------------------------------
      if (!st_r.rxsc[usss_pkg::BIT_CONTINUOUS_RECEIVE]) begin
         st_nxt.rxsc[usss_pkg::BIT_OVERRUN_ERROR] = 1'b0;
      end
      if (!rx_mode) begin
         st_nxt.rx_cnt = 4'h0;
      end else if (clk_fall) begin
         st_nxt.receive_shift_register[st_r.rx_cnt] = din;
         if (st_r.rx_cnt + 4'h1 >= usss_word_bits(st_r.rxsc[usss_pkg::BIT_NINE_BIT_RECEIVE])) begin
            st_nxt.rx_cnt = 4'h0;
            if (st_r.rx_buf_full) begin
               // Unread word still held: report error, drop new word
               st_nxt.rxsc[usss_pkg::BIT_OVERRUN_ERROR] = 1'b1;
            end else begin
               rx_done_evt = 1'b1;
               st_nxt.rx_buf_full = 1'b1;
               st_nxt.rx_buf = st_nxt.receive_shift_register[7:0];
               st_nxt.rxsc[usss_pkg::BIT_RECEIVE_NINTH] =
                  st_r.rxsc[usss_pkg::BIT_NINE_BIT_RECEIVE] && st_nxt.receive_shift_register[8];
            end
         end else begin
            st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
         end
      end

      // ----------------------------------------------------------------
      // Event flags
      // ----------------------------------------------------------------
      // Events set flags after any clear, so a set wins
      if (tx_done_evt) begin
         st_nxt.flags[usss_pkg::BIT_TRANSMIT_BUFFER_EMPTY] = 1'b1;
      end
      if (rx_done_evt) begin
         st_nxt.flags[usss_pkg::BIT_RECEIVE_COMPLETE] = 1'b1;
      end

      // ----------------------------------------------------------------
      // Read data captured in the setup phase
      // ----------------------------------------------------------------
      st_nxt.slverr = 1'b0;
      if (psel && !penable) begin
         st_nxt.rdata = 32'h00000000;
         if (hit_interrupt_control) begin
            st_nxt.rdata[7:0] = st_r.interrupt_control;
         end else if (hit_flags) begin
            st_nxt.rdata[7:0] = st_r.flags;
         end else if (hit_enables) begin
            st_nxt.rdata[7:0] = st_r.enables;
         end else if (hit_txsc) begin
            st_nxt.rdata[7:0] = st_r.txsc;
            st_nxt.rdata[usss_pkg::BIT_SHIFT_REG_EMPTY] =
               st_r.tx_state == usss_pkg::USSS_TX_IDLE;
         end else if (hit_rxsc) begin
            st_nxt.rdata[7:0] = st_r.rxsc;
         end else if (hit_rxbuf) begin
            st_nxt.rdata[7:0] = st_r.rx_buf;
         end else if (!hit_any) begin
            st_nxt.slverr = 1'b1;
         end
      end else begin
         // Cleared as the access ends, so the bus reads zero while idle
         st_nxt.rdata = 32'h00000000;
         if (psel) begin
            st_nxt.slverr = st_r.slverr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.interrupt_control <= usss_pkg::RST_INTERRUPT_CONTROL;
         st_r.flags <= usss_pkg::RST_PERIPHERAL_IRQ_FLAGS;
         st_r.enables <= usss_pkg::RST_PERIPHERAL_IRQ_ENABLES;
         st_r.txsc <= usss_pkg::RST_STATUS_CONTROL;
         st_r.rxsc <= usss_pkg::RST_STATUS_CONTROL;
         st_r.tx_state <= usss_pkg::USSS_TX_IDLE;
         // Starts at the clock's idle level so no false edge follows reset
         st_r.clk_sync <= usss_pkg::RST_CLK_SYNC;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Bus outputs
   // ----------------------------------------------------------------
   assign prdata = st_r.rdata;
   assign pready = 1'b1;
   assign pslverr = acc && st_r.slverr;

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   // Value gated by its enable so a stopped transmit leaves the line low
   assign data_pin_oe = (st_r.tx_state == usss_pkg::USSS_TX_SHIFT) && tx_mode;
   assign data_pin_out = data_pin_oe && st_r.transmit_shift_register[0];

   // ----------------------------------------------------------------
   // Interrupt outputs
   // ----------------------------------------------------------------
   // Wake needs only the source's bit in the peripheral IRQ enables register
   assign wake_req = |pending;
   assign irq_req = wake_req && st_r.interrupt_control[usss_pkg::BIT_GLOBAL_IRQ_ENABLE] &&
                    st_r.interrupt_control[usss_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
   assign irq_vector = usss_pkg::IRQ_VECTOR;

endmodule // usss_top

// *** usss_chk.sv ***
// Port-level assertions for the synchronous slave serial port.
// Assumes it is bound to usss_top and that all logic runs on clk_sys.
`timescale 1ns/1ns
module usss_chk (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic shift_clock_pin,
   input wire logic data_pin_out,
   input wire logic data_pin_oe,
   input wire logic irq_req,
   input wire logic wake_req,
   input wire logic [12:0] irq_vector
);
   logic ck_prev_r;
   logic [3:0] rise_age_r;
   logic wr_tx;
   logic wr_any;
   assign wr_any = psel && penable && pwrite;
   assign wr_tx = wr_any && (paddr[9:2] == usss_pkg::IDX_TRANSMIT_BUFFER);
   // Cycles since the raw shift clock last rose, saturating
   always_ff @(posedge clk_sys) begin
      ck_prev_r <= shift_clock_pin;
      if (!reset_n || (shift_clock_pin && !ck_prev_r)) begin
         rise_age_r <= 4'h0;
      end else if (rise_age_r != 4'hF) begin
         rise_age_r <= rise_age_r + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_vector_fixed: assert property (irq_vector == usss_pkg::IRQ_VECTOR)
      else $error("irq vector wrong");
   a_irq_needs_wake: assert property (irq_req |-> wake_req)
      else $error("irq without wake");
   a_idle_line_low: assert property (!data_pin_oe |-> !data_pin_out)
      else $error("data out high while idle");
   a_bit_after_rise: assert property (
      (data_pin_oe && $past(data_pin_oe) && $changed(data_pin_out)) |-> (rise_age_r < 4'h9))
      else $error("tx bit moved away from a clock rise");
   a_tx_from_write: assert property (
      $rose(data_pin_oe) |-> ($past(wr_tx) || $past(wr_tx, 2) || $past(wr_tx, 3)))
      else $error("transmit started without buffer write");
   a_wake_by_write: assert property ($fell(wake_req) |-> $past(wr_any))
      else $error("wake dropped without a write");
   a_read_byte_only: assert property (prdata[31:8] == 24'h000000)
      else $error("read data above bit 7");
   a_read_idle_zero: assert property (!psel |-> (prdata == 32'h00000000))
      else $error("read data while not selected");
   c_tx_done: cover property ($fell(data_pin_oe));
   c_irq_up: cover property ($rose(irq_req));
   c_wake_only: cover property (wake_req && !irq_req);
   c_slv_err: cover property (pslverr);
endmodule // usss_chk

bind usss_top usss_chk u_usss_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .shift_clock_pin(shift_clock_pin), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
   .irq_req(irq_req), .wake_req(wake_req), .irq_vector(irq_vector));

// *** usss_sync_master.sv ***
// External synchronous master: drives the shift clock, sends and captures words.
// Assumes the device drives the data pin only while data_pin_oe is high.
`timescale 1ns/1ns
module usss_sync_master (
   output logic shift_clock_pin,
   output logic data_pin_in,
   input wire logic data_pin_out,
   input wire logic data_pin_oe
);
   logic drv_en = 1'b0;
   logic drv_bit = 1'b0;
   logic held = 1'b0;
   initial shift_clock_pin = 1'b1;
   // Released line shows the inverse of the last value so stale data never passes
   assign data_pin_in = data_pin_oe ? data_pin_out : (drv_en ? drv_bit : ~held);
   // Clock idles high and runs only within a frame
   task frame(input logic [8:0] tx, input logic send, input int nbits, input int half,
              output logic [8:0] rx);
      rx = 9'h000;
      drv_en = send;
      #1;
      for (int i = 0; i < nbits; i++) begin
         drv_bit = tx[i];
         #(half);
         shift_clock_pin = 1'b0;
         rx[i] = data_pin_in;
         #(half);
         shift_clock_pin = 1'b1;
      end
      #(half);
      held = data_pin_in;
      drv_en = 1'b0;
   endtask
endmodule // usss_sync_master

// *** tb_top.sv ***
// Self-checking bench for usss_top: APB register tasks and shift-clock frames.
// Assumes zero-wait APB and the external master model beside the device.
`timescale 1ns/1ns
module tb_top;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, shift_clock_pin, data_pin_in, data_pin_out, data_pin_oe;
   logic irq_req, wake_req;
   logic [12:0] irq_vector;
   logic [31:0] q;
   logic e;
   logic [8:0] w;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #2 clk_sys = ~clk_sys;
   usss_top u_usss_top (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shift_clock_pin(shift_clock_pin),
      .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
      .irq_req(irq_req), .wake_req(wake_req), .irq_vector(irq_vector));
   usss_sync_master u_usss_sync_master (.shift_clock_pin(shift_clock_pin),
      .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));
   task close_out;
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, i, 2'b00};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, i, {24'h000000, d});
   endtask
   task rdc(input logic [7:0] i, input logic [31:0] x);
      apb(1'b0, i, 32'h00000000);
      chk(q, x);
   endtask
   task settle;
      repeat (10) @(posedge clk_sys);
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdc(usss_pkg::IDX_INTERRUPT_CONTROL, 32'h00);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 32'h00);
      apb(1'b0, 8'h40, 32'h00000000);
      chk({31'h0, e}, 32'h1);
      $display("test reset_values done");
      wr(usss_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h30);
      wr(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h10);
      wr(usss_pkg::IDX_INTERRUPT_CONTROL, 8'hC0);
      wr(usss_pkg::IDX_TRANSMIT_BUFFER, 8'hA5);
      wr(usss_pkg::IDX_TRANSMIT_BUFFER, 8'h3C);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      u_usss_sync_master.frame(9'h000, 1'b0, 8, 40, w);
      chk({23'h0, w}, 32'hA5);
      settle();
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h10);
      chk({30'h0, irq_req, wake_req}, 32'h3);
      wr(usss_pkg::IDX_INTERRUPT_CONTROL, 8'h80);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      u_usss_sync_master.frame(9'h000, 1'b0, 8, 40, w);
      chk({23'h0, w}, 32'h3C);
      settle();
      chk({30'h0, irq_req, wake_req}, 32'h1);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
      @(posedge clk_sys);
      chk({31'h0, wake_req}, 32'h0);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      $display("test transmit_pair done");
      wr(usss_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h71);
      wr(usss_pkg::IDX_TRANSMIT_BUFFER, 8'h5A);
      u_usss_sync_master.frame(9'h000, 1'b0, 9, 120, w);
      chk({23'h0, w}, 32'h15A);
      settle();
      rdc(usss_pkg::IDX_TRANSMIT_STATUS_CONTROL, 32'h73);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h10);
      $display("test transmit_nine done");
      wr(usss_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
      wr(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hB0);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h20);
      wr(usss_pkg::IDX_INTERRUPT_CONTROL, 8'hC0);
      u_usss_sync_master.frame(9'h0C3, 1'b1, 8, 40, w);
      settle();
      chk({31'h0, irq_req}, 32'h1);
      rdc(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 32'h20);
      rdc(usss_pkg::IDX_RECEIVE_BUFFER, 32'hC3);
      wr(usss_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h20);
      $display("test receive_byte done");
      wr(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hD0);
      u_usss_sync_master.frame(9'h1E7, 1'b1, 9, 40, w);
      settle();
      rdc(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'hD1);
      u_usss_sync_master.frame(9'h055, 1'b1, 9, 40, w);
      settle();
      rdc(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'hD3);
      rdc(usss_pkg::IDX_RECEIVE_BUFFER, 32'hE7);
      wr(usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'hC0);
      apb(1'b0, usss_pkg::IDX_RECEIVE_STATUS_CONTROL, 32'h00000000);
      chk(q & 32'hFE, 32'hC0);
      $display("test receive_overrun done");
      close_out();
   end
endmodule // tb_top
